// ### src/ccw_pkg.sv
/*
  Package for the 16-bit capture/compare timer: register offsets, field positions,
  reset values and the carrier structs shared by the timer files.
  Assumes a word-wide register port with no byte lanes.
*/
package ccw_pkg;

  // ==========================================================================
  // Register offsets (word index on the register port)
  // ==========================================================================
  localparam logic [3:0] CCW_OFS_CTRL   = 4'h0;
  localparam logic [3:0] CCW_OFS_MODE   = 4'h1;
  localparam logic [3:0] CCW_OFS_IOC0   = 4'h2;
  localparam logic [3:0] CCW_OFS_IOC1   = 4'h3;
  localparam logic [3:0] CCW_OFS_IEN    = 4'h4;
  localparam logic [3:0] CCW_OFS_STAT   = 4'h5;
  localparam logic [3:0] CCW_OFS_CNT    = 4'h6;
  localparam logic [3:0] CCW_OFS_GRA    = 4'h8;
  localparam logic [3:0] CCW_OFS_GRB    = 4'h9;
  localparam logic [3:0] CCW_OFS_GRC    = 4'ha;
  localparam logic [3:0] CCW_OFS_GRD    = 4'hb;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CCW_CTRL_CKS_LO  = 0;   // clock_select bits 2..0
  localparam int CCW_CTRL_CLR     = 7;   // clear_on_match_a
  localparam int CCW_MODE_BUFA    = 4;   // buffer_enable_a
  localparam int CCW_MODE_BUFB    = 5;   // buffer_enable_b
  localparam int CCW_STAT_OVF     = 7;   // overflow flag / enable; bits 3..0 are a..d

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] CCW_CNT_RST = 16'h0000;
  localparam logic [15:0] CCW_GR_RST  = 16'hffff;
  localparam logic [7:0]  CCW_REG8_RST = 8'h00;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ccw_bus_req_t;

  // io_control nibble: bit2 = capture, bits1:0 = compare action / capture edge
  typedef struct packed {
    logic       capture;
    logic [1:0] sel;
  } ccw_ioc_t;

endpackage : ccw_pkg

// ### src/ccw_prescaler.sv
/*
  Count-tick generator: picks one of six clock divisions or an external
  clock edge. Assumes ext_clk_i is synchronous to core_clk_i.
*/
`timescale 1ns/1ps
module ccw_prescaler
  import ccw_pkg::*;
#(
  parameter int DIV_W = 8
)(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       clk_en_i,
  // Control
  input  wire logic [2:0] sel_i,
  input  wire logic       ext_clk_i,
  // Tick
  output logic            tick_o
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic             ext_q;
  } ccw_pre_state_t;

  ccw_pre_state_t state_reg;
  ccw_pre_state_t state_next;
  logic           tick;

  // ==========================================================================
  // Divider and tick select
  // ==========================================================================
  always_comb
  begin
    state_next       = state_reg;
    state_next.div   = state_reg.div + 1'b1;
    state_next.ext_q = ext_clk_i;
    unique case (sel_i)
      3'h0: tick = 1'b1;
      3'h1: tick = state_reg.div[0];
      3'h2: tick = &state_reg.div[1:0];
      3'h3: tick = &state_reg.div[2:0];
      3'h4: tick = &state_reg.div[4:0];
      3'h5: tick = &state_reg.div[DIV_W-1:0];
      3'h6: tick = ext_clk_i & ~state_reg.ext_q;
      default: tick = ext_clk_i & ~state_reg.ext_q;
    endcase
  end

  assign tick_o = tick & clk_en_i;

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      state_reg <= '0;
    else if (clk_en_i)
      state_reg <= state_next;
  end

endmodule : ccw_prescaler

// ### src/ccw_edge_detect.sv
/*
  Capture-edge detector for the four capture inputs.
  Assumes the capture pins are synchronous to core_clk_i.
*/
`timescale 1ns/1ps
module ccw_edge_detect
  import ccw_pkg::*;
#(
  parameter int N = 4
)(
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  input  wire logic         clk_en_i,
  // Pins and edge choice (00 rise, 01 fall, 1x both)
  input  wire logic [N-1:0] pin_i,
  input  wire logic [2*N-1:0] edge_sel_i,
  // Detected edges
  output logic [N-1:0]      hit_o
);

  logic [N-1:0] prev_reg;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_edge
      logic rise;
      logic fall;
      assign rise = pin_i[g] & ~prev_reg[g];
      assign fall = ~pin_i[g] & prev_reg[g];
      assign hit_o[g] = clk_en_i & (edge_sel_i[2*g+1] ? (rise | fall)
                                   : (edge_sel_i[2*g] ? fall : rise));
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      prev_reg <= '0;
    else if (clk_en_i)
      prev_reg <= pin_i;
  end

endmodule : ccw_edge_detect

// ### src/ccw_timer.sv
/*
  16-bit capture/compare timer: up-counter, four general registers working as
  output compare or input capture, buffer pairing C->A and D->B, counter clear
  on match A, status flags with enables and one interrupt line.
  Assumes a CPU on a simple word register port; all inputs synchronous.
*/
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// Overview of operation
// RQ1: Readable writable 16-bit counter, selectable count clock
// RQ2: Clear counter on match A when enabled
// RQ3: Counter wrap to zero sets overflow flag
// RQ4: Overflow interrupt when overflow enable set
// RQ5: Software uses word accesses on counter only
// RQ6: Counter resets to zero
// RQ7: Four general registers, compare or capture each
// RQ8: Compare match sets the register's flag
// RQ9: Compare match interrupts when its enable set
// RQ10: Compare output action chosen by io control
// RQ11: Capture loads counter and sets flag
// RQ12: Capture interrupts when its enable set
// RQ13: Capture edge chosen by io control
// RQ14: C and D buffer A and B
// RQ15: Compare match A copies C into A
// RQ16: Capture A moves old A into C
// RQ17: Software uses word accesses on general registers
// RQ18: General registers reset to all ones
// RQ19: Flags stay set until written zero
module ccw_timer
  import ccw_pkg::*;
#(
  parameter int DIV_W = 8
)(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  // Register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // Pins
  input  wire logic        ext_clk_i,
  input  wire logic [3:0]  capture_i,
  output logic      [3:0]  compare_o,
  // Interrupt
  output logic             irq_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0]       ctrl;
    logic [7:0]       mode;
    logic [7:0]       ioc0;
    logic [7:0]       ioc1;
    logic [7:0]       ien;
    logic [7:0]       stat;
    logic [15:0]      cnt;
    logic [3:0][15:0] gr;
    logic [3:0]       cmp_out;
    logic [15:0]      rdata;
    logic             irq;
  } ccw_state_t;

  ccw_state_t   state_reg;
  ccw_state_t   state_next;
  ccw_bus_req_t req;
  logic         tick;
  logic [3:0]   cap_hit;
  logic [7:0]   edge_sel;

  // Nibble k of io_control_0/1 describes general register k
  function automatic ccw_ioc_t ioc_of(input logic [7:0] i0, input logic [7:0] i1, input int k);
    logic [3:0] nib;
    nib = (k < 2) ? ((k == 0) ? i0[3:0] : i0[7:4]) : ((k == 2) ? i1[3:0] : i1[7:4]);
    ioc_of = ccw_ioc_t'(nib[2:0]);
  endfunction : ioc_of

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sel
      ccw_ioc_t io_g;
      assign io_g                = ioc_of(state_reg.ioc0, state_reg.ioc1, g);
      assign edge_sel[2*g+1:2*g] = io_g.sel;                                    // [RQ13]
    end
  endgenerate

  // ==========================================================================
  // Submodules
  // ==========================================================================
  ccw_prescaler #(.DIV_W(DIV_W)) u_pre (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .clk_en_i   (clk_en_i),
    .sel_i      (state_reg.ctrl[CCW_CTRL_CKS_LO +: 3]), // [RQ1]
    .ext_clk_i  (ext_clk_i),
    .tick_o     (tick)
  );

  ccw_edge_detect #(.N(4)) u_edge (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .clk_en_i   (clk_en_i),
    .pin_i      (capture_i),
    .edge_sel_i (edge_sel),
    .hit_o      (cap_hit)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    logic [3:0]  match;
    logic [3:0]  cap;
    logic [3:0]  ev;
    logic        ovf_ev;
    logic        clr_a;
    logic [15:0] cnt_now;
    ccw_ioc_t    io;
    match      = '0;
    cap        = '0;
    ev         = '0;
    ovf_ev     = 1'b0;
    clr_a      = 1'b0;
    cnt_now    = state_reg.cnt;
    io         = '0;
    state_next = state_reg;
    state_next.rdata = '0;

    // Register writes first so that hardware events below win over them
    if (req.wr)
    begin
      unique case (req.addr)
        CCW_OFS_CTRL: state_next.ctrl = req.wdata[7:0];
        CCW_OFS_MODE: state_next.mode = req.wdata[7:0];
        CCW_OFS_IOC0: state_next.ioc0 = req.wdata[7:0];
        CCW_OFS_IOC1: state_next.ioc1 = req.wdata[7:0];
        CCW_OFS_IEN:  state_next.ien  = req.wdata[7:0];
        CCW_OFS_STAT: state_next.stat = state_reg.stat & req.wdata[7:0]; // [RQ19]
        CCW_OFS_CNT:  state_next.cnt  = req.wdata;                        // [RQ1]
        CCW_OFS_GRA:  state_next.gr[0] = req.wdata;
        CCW_OFS_GRB:  state_next.gr[1] = req.wdata;
        CCW_OFS_GRC:  state_next.gr[2] = req.wdata;
        CCW_OFS_GRD:  state_next.gr[3] = req.wdata;
        default: ;
      endcase
    end

    if (req.rd)
    begin
      unique case (req.addr)
        CCW_OFS_CTRL: state_next.rdata = {8'h00, state_reg.ctrl};
        CCW_OFS_MODE: state_next.rdata = {8'h00, state_reg.mode};
        CCW_OFS_IOC0: state_next.rdata = {8'h00, state_reg.ioc0};
        CCW_OFS_IOC1: state_next.rdata = {8'h00, state_reg.ioc1};
        CCW_OFS_IEN:  state_next.rdata = {8'h00, state_reg.ien};
        CCW_OFS_STAT: state_next.rdata = {8'h00, state_reg.stat};
        CCW_OFS_CNT:  state_next.rdata = state_reg.cnt;
        CCW_OFS_GRA:  state_next.rdata = state_reg.gr[0];
        CCW_OFS_GRB:  state_next.rdata = state_reg.gr[1];
        CCW_OFS_GRC:  state_next.rdata = state_reg.gr[2];
        CCW_OFS_GRD:  state_next.rdata = state_reg.gr[3];
        default:      state_next.rdata = '0;
      endcase
    end

    // Compare and capture, per general register
    for (int k = 0; k < 4; k++)
    begin
      io = ioc_of(state_reg.ioc0, state_reg.ioc1, k);             // [RQ7]
      if (io.capture)
        cap[k] = cap_hit[k];                                      // [RQ11]
      else
        match[k] = tick & (state_reg.cnt == state_reg.gr[k]);     // [RQ8]
      if (match[k])
      begin
        unique case (io.sel)                                      // [RQ10]
          2'h0: state_next.cmp_out[k] = state_reg.cmp_out[k];
          2'h1: state_next.cmp_out[k] = 1'b0;
          2'h2: state_next.cmp_out[k] = 1'b1;
          2'h3: state_next.cmp_out[k] = ~state_reg.cmp_out[k];
        endcase
      end
      if (cap[k])
        state_next.gr[k] = cnt_now;                               // [RQ11]
      ev[k] = match[k] | cap[k];
    end

    // Buffer pairs: C behind A, D behind B
    for (int k = 0; k < 2; k++)
    begin
      if (state_reg.mode[CCW_MODE_BUFA + k])                      // [RQ14]
      begin
        if (match[k])
          state_next.gr[k] = state_reg.gr[k+2];                   // [RQ15]
        if (cap[k])
          state_next.gr[k+2] = state_reg.gr[k];                   // [RQ16]
      end
    end

    // Counter
    clr_a = match[0] & state_reg.ctrl[CCW_CTRL_CLR];
    if (tick)
    begin
      if (clr_a)
        state_next.cnt = CCW_CNT_RST;                             // [RQ2]
      else
      begin
        state_next.cnt = state_reg.cnt + 16'h0001;
        ovf_ev         = (state_reg.cnt == 16'hffff);             // [RQ3]
      end
    end

    // Sticky flags: set wins over a software clear in the same cycle
    state_next.stat[3:0] = state_next.stat[3:0] | ev;             // [RQ19]
    if (ovf_ev)
      state_next.stat[CCW_STAT_OVF] = 1'b1;                       // [RQ3]

    state_next.irq = |(state_next.stat & state_next.ien);         // [RQ4] [RQ9] [RQ12]
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_reg       <= '0;
      state_reg.cnt   <= CCW_CNT_RST;                             // [RQ6]
      state_reg.gr    <= {4{CCW_GR_RST}};                         // [RQ18]
      state_reg.ctrl  <= CCW_REG8_RST;
    end
    else if (clk_en_i)
      state_reg <= state_next;
  end

  assign rdata_o   = state_reg.rdata;
  assign compare_o = state_reg.cmp_out;
  assign irq_o     = state_reg.irq;

endmodule : ccw_timer

// ### testbench/ccw_timer_chk.sv
/* Port assertions for ccw_timer.
   Assumes ccw_pkg is compiled first. */
`timescale 1ns/1ps
module ccw_timer_chk
  import ccw_pkg::*;
(
  // Clock, reset, register port
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  input wire logic        clk_en_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  // Pins
  input wire logic        ext_clk_i,
  input wire logic [3:0]  capture_i,
  input wire logic [3:0]  compare_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================
  // Last control values taken by the port
  logic [7:0] ctrl_q;
  logic [7:0] ien_q;
  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
    begin
      ctrl_q <= 8'h00;
      ien_q  <= 8'h00;
    end
    else if (wr_i && clk_en_i)
    begin
      if (addr_i == CCW_OFS_CTRL) ctrl_q <= wdata_i[7:0];
      if (addr_i == CCW_OFS_IEN) ien_q <= wdata_i[7:0];
    end
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (rd_i && clk_en_i && (addr_i == 4'h7 || addr_i > 4'hb)
    |=> rdata_o == 16'h0000) else $error("unmapped read not zero");
  a_upper_zero: assert property (rd_i && clk_en_i && addr_i < CCW_OFS_CNT
    |=> rdata_o[15:8] == 8'h00) else $error("upper byte not zero");
  a_ctrl_readback: assert property (rd_i && clk_en_i && addr_i == CCW_OFS_CTRL
    |=> (rdata_o[7:0] & 8'h87) == (ctrl_q & 8'h87)) else $error("control readback");
  a_ien_readback: assert property (rd_i && clk_en_i && addr_i == CCW_OFS_IEN
    |=> (rdata_o[7:0] & 8'h8f) == (ien_q & 8'h8f)) else $error("enable readback");
  a_irq_masked: assert property (ien_q == 8'h00 && $past(ien_q) == 8'h00 |-> !irq_o)
    else $error("interrupt with all enables off");
  a_freeze_cmp: assert property (!$past(clk_en_i) |-> $stable(compare_o))
    else $error("compare output moved while frozen");
  a_freeze_irq: assert property (!clk_en_i ##1 !clk_en_i |-> $stable(irq_o))
    else $error("interrupt moved while frozen");
endmodule : ccw_timer_chk

bind ccw_timer ccw_timer_chk ccw_timer_chk_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .clk_en_i(clk_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .ext_clk_i(ext_clk_i), .capture_i(capture_i), .compare_o(compare_o), .irq_o(irq_o));

// ### testbench/ccw_cpu_model.sv
/* CPU side of the register port.
   Assumes read data stand in the cycle after the strobe. */
`timescale 1ns/1ps
module ccw_cpu_model
  import ccw_pkg::*;
(
  // Clock and read data
  input  wire logic        core_clk_i,
  input  wire logic [15:0] rdata_i,
  // Request
  output ccw_bus_req_t     req_o
);
  initial req_o = '0;
  // ==========================================
  // Word accesses only; released lines go inverted
  task automatic wr_word(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr_word
  task automatic rd_word(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    req_o <= '{addr: a, wdata: 16'h5a5a, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req_o <= '{addr: ~a, wdata: 16'ha5a5, wr: 1'b0, rd: 1'b0};
    @(posedge core_clk_i);
    d = rdata_i;
  endtask : rd_word
endmodule : ccw_cpu_model

// ### testbench/testbench.sv
/* Self-checking bench for ccw_timer.
   Assumes the checker binds itself; counting runs from the external clock pin except in the reset and division checks. */
`timescale 1ns/1ps
module testbench
  import ccw_pkg::*;
;
  logic         core_clk_i, reset_i, clk_en_i, ext_clk_i, irq_o;
  logic [3:0]   capture_i, compare_o;
  logic [15:0]  rdata_o, v, g;
  logic [15:0]  m [16];
  ccw_bus_req_t req;
  int           n_mismatch = 0;
  int           cmp_count = 0;
  int           seed;
  int           d;
  ccw_timer #(.DIV_W(8)) ccw_timer_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .addr_i(req.addr), .wdata_i(req.wdata), .wr_i(req.wr), .rd_i(req.rd), .rdata_o(rdata_o),
    .ext_clk_i(ext_clk_i), .capture_i(capture_i), .compare_o(compare_o), .irq_o(irq_o));
  ccw_cpu_model ccw_cpu_model_inst (.core_clk_i(core_clk_i), .rdata_i(rdata_o), .req_o(req));
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ==========================================
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] x);
    cmp_count++;
    if (x !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, x);
      n_mismatch++;
    end
  endtask : chk
  task automatic w(input logic [3:0] a, input logic [15:0] d);
    m[a] = d;
    ccw_cpu_model_inst.wr_word(a, d);
  endtask : w
  task automatic r(input logic [3:0] a, input string nm, input logic [15:0] e);
    ccw_cpu_model_inst.rd_word(a, g);
    chk(nm, e, g);
  endtask : r
  // One count edge per pulse, then let the tick land
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk_i) ext_clk_i <= 1'b1;
      @(posedge core_clk_i) ext_clk_i <= 1'b0;
    end
    repeat (3) @(posedge core_clk_i);
  endtask : tick
  task automatic wait_irq(input logic e);
    for (int i = 0; i < 8 && irq_o !== e; i++) @(posedge core_clk_i);
    chk("irq_o", {15'h0, e}, {15'h0, irq_o});
  endtask : wait_irq
  task automatic cap(input int b, input logic lvl);
    @(posedge core_clk_i) capture_i[b] <= lvl;
    repeat (3) @(posedge core_clk_i);
  endtask : cap
  initial
  begin
    repeat (100000) @(posedge core_clk_i);
    n_mismatch++;
    close_out();
  end
  // ==========================================
  initial
  begin
    seed = 32'ha0df1b90;
    reset_i = 1'b1;
    clk_en_i = 1'b1;
    ext_clk_i = 1'b0;
    capture_i = 4'h0;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    ccw_cpu_model_inst.rd_word(CCW_OFS_CNT, v);
    ccw_cpu_model_inst.rd_word(CCW_OFS_CNT, g);
    chk("cnt_reset", 16'h0001, {15'h0, v < 16'h0008});
    chk("cnt_step", v + 16'h0003, g);
    for (int a = 8; a < 12; a++) r(a[3:0], "gr_reset", CCW_GR_RST);
    r(4'h7, "unmapped", 16'h0000);
    w(CCW_OFS_CTRL, 16'h0006);
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      w(CCW_OFS_CNT, v);
      r(CCW_OFS_CNT, "cnt_wr", v);
    end
    tick(3);
    r(CCW_OFS_CNT, "cnt_ext", v + 16'h0003);
    // Wrap also matches the four general registers at ffff
    w(CCW_OFS_CNT, 16'hffff);
    w(CCW_OFS_IEN, 16'h0080);
    tick(1);
    r(CCW_OFS_CNT, "cnt_wrap", 16'h0000);
    r(CCW_OFS_STAT, "stat_wrap", 16'h008f);
    wait_irq(1'b1);
    clk_en_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    r(CCW_OFS_STAT, "stat_held", 16'h008f);
    w(CCW_OFS_STAT, 16'h0000);
    wait_irq(1'b0);
    w(CCW_OFS_IEN, 16'h0001);
    r(CCW_OFS_IEN, "ien", 16'h0001);
    w(CCW_OFS_IOC0, 16'h0003);
    w(CCW_OFS_GRA, 16'h0005);
    w(CCW_OFS_GRC, 16'h0009);
    w(CCW_OFS_MODE, 16'h0010);
    w(CCW_OFS_CNT, 16'h0004);
    w(CCW_OFS_CTRL, 16'h0086);
    r(CCW_OFS_CTRL, "ctrl", 16'h0086);
    tick(2);
    r(CCW_OFS_CNT, "cnt_clr", 16'h0000);
    r(CCW_OFS_STAT, "flag_a", 16'h0001);
    chk("cmp_a", 16'h0001, {15'h0, compare_o[0]});
    r(CCW_OFS_GRA, "buf_a", m[CCW_OFS_GRC]);
    wait_irq(1'b1);
    w(CCW_OFS_IEN, 16'h0000);
    for (int s = 1; s < 4; s++)
    begin
      w(CCW_OFS_IOC0, 16'(s << 4) | 16'h0003);
      w(CCW_OFS_GRB, 16'h0010);
      w(CCW_OFS_CNT, 16'h0010);
      tick(1);
      chk("cmp_b", {15'h0, s == 2}, {15'h0, compare_o[1]});
    end
    w(CCW_OFS_STAT, 16'h0000);
    w(CCW_OFS_MODE, 16'h0000);
    w(CCW_OFS_IEN, 16'h0004);
    // Rise, fall, both; the pin alternates so each code sees its own edge
    for (int k = 0; k < 3; k++)
    begin
      w(CCW_OFS_IOC1, 16'h0004 | 16'(k));
      v = $random(seed);
      w(CCW_OFS_CNT, v);
      cap(2, k != 1);
      r(CCW_OFS_GRC, "cap_c", v);
    end
    r(CCW_OFS_STAT, "flag_c", 16'h0004);
    wait_irq(1'b1);
    w(CCW_OFS_STAT, 16'h0000);
    w(CCW_OFS_IEN, 16'h0000);
    w(CCW_OFS_MODE, 16'h0010);
    w(CCW_OFS_GRA, 16'h1234);
    w(CCW_OFS_IOC0, 16'h0004);
    v = $random(seed);
    w(CCW_OFS_CNT, v);
    cap(0, 1'b1);
    r(CCW_OFS_GRA, "cap_a", v);
    r(CCW_OFS_GRC, "buf_c", m[CCW_OFS_GRA]);
    // Internal divisions: 67 clock cycles between the two read edges
    for (int s = 1; s < 5; s++)
    begin
      w(CCW_OFS_CTRL, 16'(s));
      ccw_cpu_model_inst.rd_word(CCW_OFS_CNT, v);
      repeat (64) @(posedge core_clk_i);
      ccw_cpu_model_inst.rd_word(CCW_OFS_CNT, g);
      d = 67 >> ((s == 4) ? 5 : s);
      chk("cnt_div", 16'h0001, {15'h0, (16'(g - v) == 16'(d)) || (16'(g - v) == 16'(d + 1))});
    end
    close_out();
  end
endmodule : testbench
